//--- rtl/move_sequencer.sv
// Block-move sequencer with an AHB-Lite register slave.
// Assumes a single clock, synchronous reset, whole-word single transfers.
// How it works
// RQ1: Postincrement host moves add 32 to the host pointer per word.
// RQ2: Predecrement subtracts 32 before each word; local pointer increments after.
// RQ3: Local-port word pointer increments by exactly 1 per word.
// RQ4: Local-to-host count is 1..32; absent count means one transfer.
// RQ5: Transfers field value 0 means 32 transfers; register-to-register moves take 0 as 15 instead.
// RQ6: Word-order bit set sends low fraction word first for doubles.
// RQ7: Word-order bit clear sends upper word first for doubles.
// RQ8: Word-order bit resets to 0.
// RQ9: Integer and single moves step the register after every word.
// RQ10: Double moves count 64-bit values and step register every second word.
// RQ11: Register-to-register count is 1..15; absent count moves one.
// RQ12: Register-to-register moves step both source and destination each move.
// RQ13: One variant takes its first source from the first register file.
// RQ14: The other variant takes its first source from the second register file.
// RQ15: Transfers count down; done flags after the last word, pointers kept.
// RQ16: Out-of-range counts clamp to the maximum allowed count.
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module move_sequencer (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [31:0] REG_READ_DATA,
    output logic [5:0] COPRO_SOURCE_REG,
    output logic [5:0] COPRO_DEST_REG,
    output logic REG_WRITE,
    output logic [31:0] HOST_ADDRESS,
    output logic [31:0] HOST_DATA,
    output logic HOST_STROBE,
    output logic [31:0] LOCAL_PORT_WORD_POINTER,
    output logic LOCAL_READ,
    output logic BUSY,
    output logic HIGH_WORD
);
    import move_seq_pkg::*;

    move_link_if link ();
    move_word_engine engine (
        .clk(CLK),
        .reset(RESET),
        .link(link)
    );

    // Bus address phase capture
    logic wr_pending;
    logic [7:0] wr_addr;
    logic rd_pending;
    logic [7:0] rd_addr;
    logic [31:0] next_hrdata;
    logic bus_write;

    // Control state
    logic word_order;
    logic predec;
    logic second_file;
    move_kind_t kind;
    logic [31:0] host_ptr;
    logic [31:0] local_ptr;
    logic [4:0] src_idx;
    logic [4:0] dst_idx;
    logic half;
    logic done;
    logic clamped;
    logic launch;
    logic [5:0] launch_count;

    logic next_word_order;
    logic next_predec;
    logic next_second_file;
    move_kind_t next_kind;
    logic [31:0] next_host_ptr;
    logic [31:0] next_local_ptr;
    logic [4:0] next_src_idx;
    logic [4:0] next_dst_idx;
    logic next_half;
    logic next_done;
    logic next_clamped;
    logic next_launch;
    logic [5:0] next_launch_count;

    logic [5:0] field_count;
    logic [5:0] words;
    logic over;
    logic is_double;
    logic is_rr;
    logic is_local;

    assign bus_write = wr_pending;
    assign field_count = {1'b0, HWDATA[CMD_COUNT_LSB +: 5]};

    // Count decode for the command being written
    always_comb begin
        words = 6'h01;
        over = 1'b0;
        if (HWDATA[CMD_COUNT_GIVEN_BIT]) begin
            case (move_kind_t'(HWDATA[CMD_KIND_LSB +: 3]))
                KIND_REG_TO_REG: begin
                    if (field_count == 6'h00 || field_count > MAX_REG_COUNT) begin
                        words = MAX_REG_COUNT; // [RQ11] [RQ16]
                        over = 1'b1;
                    end else begin
                        words = field_count; // [RQ11]
                    end
                end
                KIND_DOUBLE_TO_MEM: begin
                    if (field_count == 6'h00 || field_count > 6'h10) begin
                        words = MAX_WORD_COUNT; // [RQ16]
                        over = field_count != 6'h00;
                    end else begin
                        words = {field_count[4:0], 1'b0}; // [RQ10]
                    end
                end
                KIND_INT_TO_MEM, KIND_SINGLE_TO_MEM, KIND_LOCAL_TO_HOST: begin
                    words = (field_count == 6'h00) ? MAX_WORD_COUNT : field_count; // [RQ4] [RQ5]
                end
                default: begin
                    words = 6'h01; // [RQ16]
                    over = 1'b1;
                end
            endcase
        end else if (move_kind_t'(HWDATA[CMD_KIND_LSB +: 3]) == KIND_DOUBLE_TO_MEM) begin
            words = 6'h02; // [RQ10]
        end
    end

    assign is_double = (kind == KIND_DOUBLE_TO_MEM);
    assign is_rr = (kind == KIND_REG_TO_REG);
    assign is_local = (kind == KIND_LOCAL_TO_HOST);

    always_comb begin
        next_word_order = word_order;
        next_predec = predec;
        next_second_file = second_file;
        next_kind = kind;
        next_host_ptr = host_ptr;
        next_local_ptr = local_ptr;
        next_src_idx = src_idx;
        next_dst_idx = dst_idx;
        next_half = half;
        next_done = done;
        next_clamped = clamped;
        next_launch = 1'b0;
        next_launch_count = launch_count;
        if (bus_write && !link.busy && !launch) begin
            case (wr_addr)
                OFS_CONFIG: next_word_order = HWDATA[CFG_WORD_ORDER_BIT];
                OFS_HOST_POINTER: next_host_ptr = HWDATA;
                OFS_LOCAL_POINTER: next_local_ptr = HWDATA;
                OFS_COMMAND: begin
                    next_kind = move_kind_t'(HWDATA[CMD_KIND_LSB +: 3]);
                    next_predec = HWDATA[CMD_PREDEC_BIT];
                    next_second_file = HWDATA[CMD_SRC_FILE_BIT]; // [RQ13] [RQ14]
                    next_src_idx = HWDATA[CMD_SRC_LSB +: 5];
                    next_dst_idx = HWDATA[CMD_DST_LSB +: 5];
                    next_launch_count = words;
                    next_clamped = over;
                    next_half = 1'b0;
                    next_done = 1'b0;
                    next_launch = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (link.step) begin
            if (!is_rr) begin
                if (predec) begin
                    next_host_ptr = host_ptr - HOST_STEP; // [RQ2]
                end else begin
                    next_host_ptr = host_ptr + HOST_STEP; // [RQ1]
                end
            end
            if (is_local) begin
                next_local_ptr = local_ptr + LOCAL_STEP; // [RQ3] [RQ2]
            end else if (is_rr) begin
                next_src_idx = src_idx + REG_STEP; // [RQ12]
                next_dst_idx = dst_idx + REG_STEP; // [RQ12]
            end else if (is_double) begin
                next_half = !half;
                if (half) begin
                    next_src_idx = src_idx + REG_STEP; // [RQ10]
                end
            end else begin
                next_src_idx = src_idx + REG_STEP; // [RQ9]
            end
            if (link.last) begin
                next_done = 1'b1; // [RQ15]
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            word_order <= CFG_WORD_ORDER_RESET; // [RQ8]
            predec <= 1'b0;
            second_file <= 1'b0;
            kind <= KIND_INT_TO_MEM;
            host_ptr <= 32'h00000000;
            local_ptr <= 32'h00000000;
            src_idx <= 5'h00;
            dst_idx <= 5'h00;
            half <= 1'b0;
            done <= 1'b0;
            clamped <= 1'b0;
            launch <= 1'b0;
            launch_count <= 6'h01;
        end else begin
            word_order <= next_word_order;
            predec <= next_predec;
            second_file <= next_second_file;
            kind <= next_kind;
            host_ptr <= next_host_ptr;
            local_ptr <= next_local_ptr;
            src_idx <= next_src_idx;
            dst_idx <= next_dst_idx;
            half <= next_half;
            done <= next_done;
            clamped <= next_clamped;
            launch <= next_launch;
            launch_count <= next_launch_count;
        end
    end

    assign link.start = launch;
    assign link.count = launch_count;
    assign link.pair_mode = is_double;

    // Bus slave: zero wait states, writes land in the data phase
    always_comb begin
        next_hrdata = 32'h00000000;
        case (rd_addr)
            OFS_CONFIG: next_hrdata = {31'h00000000, word_order};
            OFS_STATUS: next_hrdata = {29'h00000000, clamped, done, link.busy | launch};
            OFS_HOST_POINTER: next_hrdata = host_ptr;
            OFS_LOCAL_POINTER: next_hrdata = local_ptr;
            OFS_REG_INDEX: next_hrdata = {11'h000, dst_idx, 11'h000, src_idx};
            default: next_hrdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_pending <= 1'b0;
            rd_pending <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
        end else begin
            wr_pending <= HREADY && HSEL && HTRANS[1] && HWRITE;
            rd_pending <= HREADY && HSEL && HTRANS[1] && !HWRITE;
            if (HREADY && HSEL && HTRANS[1]) begin
                wr_addr <= HADDR[7:0];
                rd_addr <= HADDR[7:0];
            end
        end
    end

    assign HRDATA = rd_pending ? next_hrdata : 32'h00000000;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // Datapath strobes and addresses, registered
    always_ff @(posedge CLK) begin
        if (RESET) begin
            COPRO_SOURCE_REG <= 6'h00;
            COPRO_DEST_REG <= 6'h00;
            REG_WRITE <= 1'b0;
            HOST_ADDRESS <= 32'h00000000;
            HOST_DATA <= 32'h00000000;
            HOST_STROBE <= 1'b0;
            LOCAL_PORT_WORD_POINTER <= 32'h00000000;
            LOCAL_READ <= 1'b0;
            BUSY <= 1'b0;
            HIGH_WORD <= 1'b0;
        end else begin
            // Read address leads the strobe by one cycle so the word is read in its step
            COPRO_SOURCE_REG <= {next_second_file, next_src_idx}; // [RQ9]
            COPRO_DEST_REG <= {!second_file, dst_idx};
            REG_WRITE <= link.step && is_rr;
            HOST_ADDRESS <= predec ? host_ptr - HOST_STEP : host_ptr; // [RQ2]
            HOST_DATA <= REG_READ_DATA;
            HOST_STROBE <= link.step && !is_rr;
            LOCAL_PORT_WORD_POINTER <= local_ptr;
            LOCAL_READ <= link.step && is_local;
            BUSY <= link.busy | launch;
            HIGH_WORD <= (next_kind == KIND_DOUBLE_TO_MEM) && (next_half == next_word_order); // [RQ6] [RQ7]
        end
    end
endmodule : move_sequencer
`default_nettype wire

//--- rtl/move_seq_pkg.sv
// Constants and types shared by the block-move sequencer and its
// word-transfer engine; nothing is assumed about the surroundings.
package move_seq_pkg;
    // Register map, byte addresses of one aligned word each
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_COMMAND = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_HOST_POINTER = 8'h0C;
    localparam logic [7:0] OFS_LOCAL_POINTER = 8'h10;
    localparam logic [7:0] OFS_REG_INDEX = 8'h14;
    // Config fields
    localparam int CFG_WORD_ORDER_BIT = 0;
    localparam logic CFG_WORD_ORDER_RESET = 1'b0;
    // Command fields: [2:0] kind, [3] predecrement, [4] second-file source,
    // [9:5] transfers, [10] count given, [15:11] source reg, [20:16] dest reg
    localparam int CMD_KIND_LSB = 0;
    localparam int CMD_PREDEC_BIT = 3;
    localparam int CMD_SRC_FILE_BIT = 4;
    localparam int CMD_COUNT_LSB = 5;
    localparam int CMD_COUNT_GIVEN_BIT = 10;
    localparam int CMD_SRC_LSB = 11;
    localparam int CMD_DST_LSB = 16;
    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_CLAMPED_BIT = 2;
    // Counts and steps
    localparam logic [5:0] MAX_WORD_COUNT = 6'h20;
    localparam logic [5:0] MAX_REG_COUNT = 6'h0F;
    localparam logic [31:0] HOST_STEP = 32'h00000020;
    localparam logic [31:0] LOCAL_STEP = 32'h00000001;
    localparam logic [4:0] REG_STEP = 5'h01;

    typedef enum logic [2:0] {
        KIND_INT_TO_MEM,
        KIND_SINGLE_TO_MEM,
        KIND_DOUBLE_TO_MEM,
        KIND_REG_TO_REG,
        KIND_LOCAL_TO_HOST
    } move_kind_t;
endpackage : move_seq_pkg

//--- rtl/move_link_if.sv
// Word hand-off between the sequencer and its transfer engine.
// Assumes both ends run on one clock.
`timescale 1ns/1ps
`default_nettype none
interface move_link_if;
    logic start;
    logic [5:0] count;
    logic pair_mode;
    logic step;
    logic last;
    logic busy;
    modport seq (output start, output count, output pair_mode, input step, input last,
        input busy);
    modport eng (input start, input count, input pair_mode, output step, output last,
        output busy);
endinterface : move_link_if
`default_nettype wire

//--- rtl/move_word_engine.sv
// Counts the 32-bit beats of one move; one beat per cycle once started.
// Assumes count was already decoded to 1..32 by the sequencer.
`timescale 1ns/1ps
`default_nettype none
module move_word_engine (
    input wire logic clk,
    input wire logic reset,
    move_link_if.eng link
);
    import move_seq_pkg::*;
    logic [5:0] remaining;
    logic [5:0] next_remaining;
    logic active;
    logic next_active;

    always_comb begin
        next_remaining = remaining;
        next_active = active;
        if (link.start && !active) begin
            next_remaining = link.count;
            next_active = 1'b1;
        end else if (active) begin
            next_remaining = remaining - 6'h01; // [RQ15]
            if (remaining == 6'h01) begin
                next_active = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            remaining <= 6'h00;
            active <= 1'b0;
        end else begin
            remaining <= next_remaining;
            active <= next_active;
        end
    end

    assign link.step = active;
    assign link.last = active && (remaining == 6'h01);
    assign link.busy = active;
endmodule : move_word_engine
`default_nettype wire

//--- sim/move_seq_assertions.sv
// Port checker for the block-move sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module move_seq_assertions (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [5:0] COPRO_SOURCE_REG,
    input wire logic [5:0] COPRO_DEST_REG,
    input wire logic REG_WRITE,
    input wire logic [31:0] HOST_ADDRESS,
    input wire logic HOST_STROBE,
    input wire logic [31:0] LOCAL_PORT_WORD_POINTER,
    input wire logic LOCAL_READ,
    input wire logic BUSY,
    input wire logic HIGH_WORD
);
    logic [6:0] run_host, run_reg, next_run_host, next_run_reg;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Length of the current unbroken burst
    always_comb begin
        next_run_host = HOST_STROBE ? run_host + 7'h01 : 7'h00;
        next_run_reg = REG_WRITE ? run_reg + 7'h01 : 7'h00;
    end
    always_ff @(posedge CLK) begin
        run_host <= RESET ? 7'h00 : next_run_host;
        run_reg <= RESET ? 7'h00 : next_run_reg;
    end
    a_host_step: assert property (
        HOST_STROBE && $past(HOST_STROBE) |->
        (HOST_ADDRESS - $past(HOST_ADDRESS)) inside {32'h20, 32'hFFFFFFE0})
        else $error("host address step wrong");
    a_local_step: assert property (
        BUSY && $past(BUSY) && $changed(LOCAL_PORT_WORD_POINTER) |->
        LOCAL_PORT_WORD_POINTER == $past(LOCAL_PORT_WORD_POINTER) + 32'h1)
        else $error("local pointer step wrong");
    a_host_burst: assert property (HOST_STROBE |-> run_host < 7'h20)
        else $error("too many host words");
    a_reg_burst: assert property (REG_WRITE |-> run_reg < 7'h0F)
        else $error("too many register moves");
    a_reg_step: assert property (
        REG_WRITE && $past(REG_WRITE) |->
        COPRO_SOURCE_REG[4:0] == $past(COPRO_SOURCE_REG[4:0]) + 5'h01 &&
        COPRO_DEST_REG[4:0] == $past(COPRO_DEST_REG[4:0]) + 5'h01)
        else $error("register pair not advanced");
    a_dest_file: assert property (
        REG_WRITE |-> COPRO_DEST_REG[5] != COPRO_SOURCE_REG[5])
        else $error("destination in source file");
    a_word_pair: assert property (
        HOST_STROBE && $past(HOST_STROBE) && (HIGH_WORD || $past(HIGH_WORD)) |->
        HIGH_WORD != $past(HIGH_WORD))
        else $error("double halves not alternating");
    a_busy_bound: assert property ($rose(BUSY) |-> ##[1:40] !BUSY)
        else $error("move did not finish");
    a_pulse_busy: assert property (
        HOST_STROBE || REG_WRITE || LOCAL_READ |-> BUSY || $past(BUSY))
        else $error("transfer while idle");
    cover property (HOST_STROBE && HIGH_WORD);
    cover property (REG_WRITE && $past(REG_WRITE));
    cover property (LOCAL_READ);
    cover property ($fell(BUSY));
endmodule : move_seq_assertions
`default_nettype wire

//--- sim/regfile_host_model.sv
// Far side: register file words out, host-memory and register writes logged.
// Assumes one word per strobe on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module regfile_host_model (
    input wire logic clk,
    input wire logic [5:0] source_reg,
    input wire logic [5:0] dest_reg,
    input wire logic high_word,
    input wire logic host_strobe,
    input wire logic reg_write,
    input wire logic [31:0] host_address,
    input wire logic [31:0] host_data,
    output logic [31:0] read_data
);
    logic [31:0] host_log[$];
    logic [31:0] data_log[$];
    logic [11:0] move_log[$];
    // Source was read one cycle before its register write
    logic [5:0] prev_source;
    // Each word names its register and half so its origin can be traced
    assign read_data = {16'hC0DE, 9'h000, high_word, source_reg};
    always @(posedge clk) begin
        prev_source <= source_reg;
        if (host_strobe === 1'b1) begin
            host_log.push_back(host_address);
            data_log.push_back(host_data);
        end
        if (reg_write === 1'b1)
            move_log.push_back({prev_source, dest_reg});
    end
endmodule : regfile_host_model
`default_nettype wire

//--- sim/coproc_block_move_sequencer_tb.sv
// Self-checking bench: AHB-Lite master, reference model, far side.
// Assumes the sequencer, its package, the far-side model and the checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module coproc_block_move_sequencer_tb;
    import move_seq_pkg::*;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic HREADY, HREADYOUT, HRESP, REG_WRITE, HOST_STROBE, LOCAL_READ, BUSY, HIGH_WORD;
    logic [31:0] HRDATA, REG_READ_DATA, HOST_ADDRESS, HOST_DATA, LOCAL_PORT_WORD_POINTER;
    logic [5:0] COPRO_SOURCE_REG, COPRO_DEST_REG;
    logic [31:0] rd;
    int fails = 0;
    int compares = 0;
    int seed = 61;
    int lreads = 0;
    assign HREADY = HREADYOUT;
    move_sequencer dut (.CLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY, .HRDATA, .HREADYOUT, .HRESP, .REG_READ_DATA, .COPRO_SOURCE_REG,
        .COPRO_DEST_REG, .REG_WRITE, .HOST_ADDRESS, .HOST_DATA, .HOST_STROBE,
        .LOCAL_PORT_WORD_POINTER, .LOCAL_READ, .BUSY, .HIGH_WORD);
    regfile_host_model far (.clk(CLK), .source_reg(COPRO_SOURCE_REG),
        .dest_reg(COPRO_DEST_REG), .high_word(HIGH_WORD), .host_strobe(HOST_STROBE),
        .reg_write(REG_WRITE), .host_address(HOST_ADDRESS), .host_data(HOST_DATA),
        .read_data(REG_READ_DATA));
    initial forever #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (LOCAL_READ === 1'b1)
            lreads++;
    end
    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic ready_edge;
        int n;
        n = 0;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) begin
            n++;
            if (n > 50) begin
                fails++;
                report_and_stop();
            end
            @(posedge CLK);
        end
    endtask : ready_edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        ready_edge();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        ready_edge();
        r = HRDATA;
        `CHK(HRESP, 1'b0)
    endtask : ahb
    function automatic int words(int kind, int cnt, logic given);
        if (!given) return kind == 2 ? 2 : 1;
        if (kind > 4) return 1;
        if (kind == 3) return (cnt == 0 || cnt > 15) ? 15 : cnt;
        if (kind == 2) return (cnt == 0 || cnt > 16) ? 32 : 2 * cnt;
        return cnt == 0 ? 32 : cnt;
    endfunction : words
    task automatic run_cmd(input int kind, input int cnt, input logic given,
        input logic pre, input logic order);
        logic [31:0] hp, lp, st;
        logic [4:0] src, dst, s;
        logic file, clamp;
        int n, i;
        hp = $random(seed);
        lp = $random(seed);
        src = 5'($random(seed));
        dst = 5'($random(seed));
        file = 1'($random(seed));
        n = words(kind, cnt, given);
        clamp = given && (kind > 4 || (kind == 2 && cnt > 16) || (kind == 3 && (cnt == 0 || cnt > 15)));
        lreads = 0;
        far.host_log.delete();
        far.data_log.delete();
        far.move_log.delete();
        ahb(1'b1, OFS_CONFIG, {31'h0, order}, st);
        ahb(1'b1, OFS_HOST_POINTER, hp, st);
        ahb(1'b1, OFS_LOCAL_POINTER, lp, st);
        ahb(1'b1, OFS_COMMAND, {11'h0, dst, src, given, 5'(cnt), file, pre, 3'(kind)}, st);
        ahb(1'b1, OFS_HOST_POINTER, 32'hDEADBEEF, st);
        i = 0;
        do begin
            ahb(1'b0, OFS_STATUS, 32'h0, st);
            i++;
        end while (st[1:0] !== 2'b10 && i < 60);
        if (i >= 60) begin
            fails++;
            report_and_stop();
        end
        // Let the last strobe be logged before the counts are compared
        repeat (2) @(posedge CLK);
        `CHK(st[2:0], {clamp, 2'b10})
        `CHK(far.host_log.size(), kind == 3 ? 0 : n)
        `CHK(far.move_log.size(), kind == 3 ? n : 0)
        `CHK(lreads, kind == 4 ? n : 0)
        for (i = 0; i < n; i++) begin
            s = src + 5'(kind == 2 ? i / 2 : i);
            if (kind == 3)
                `CHK(far.move_log[i], {file, s, !file, dst + 5'(i)})
            else
                `CHK(far.host_log[i], pre ? hp - 32 * (i + 1) : hp + 32 * i)
            if (kind < 2)
                `CHK(far.data_log[i][5:0], {file, s})
            if (kind == 2)
                `CHK(far.data_log[i][6:0], {order ^ !i[0], file, s})
        end
        ahb(1'b0, OFS_HOST_POINTER, 32'h0, st);
        `CHK(st, kind == 3 ? hp : pre ? hp - 32 * n : hp + 32 * n)
        `CHK(LOCAL_PORT_WORD_POINTER, kind == 4 ? lp + n : lp)
    endtask : run_cmd
    initial begin
        repeat (20) @(posedge CLK);
        RESET <= 1'b0;
        ahb(1'b0, OFS_CONFIG, 32'h0, rd);
        `CHK(rd, 32'h0)
        ahb(1'b0, 8'h18, 32'h0, rd);
        `CHK(rd, 32'h0)
        for (int k = 0; k < 10; k++)
            run_cmd(k % 5, 1 + {$random(seed)} % 15, 1'b1, 1'(k / 5), 1'(k));
        run_cmd(0, 0, 1'b1, 1'b0, 1'b0);
        run_cmd(1, 31, 1'b1, 1'b1, 1'b0);
        run_cmd(4, 0, 1'b1, 1'b1, 1'b0);
        run_cmd(2, 0, 1'b1, 1'b0, 1'b1);
        run_cmd(2, 20, 1'b1, 1'b1, 1'b0);
        run_cmd(3, 0, 1'b1, 1'b0, 1'b0);
        run_cmd(3, 20, 1'b1, 1'b0, 1'b1);
        run_cmd(2, 5, 1'b0, 1'b0, 1'b1);
        run_cmd(4, 9, 1'b0, 1'b0, 1'b0);
        run_cmd(3, 7, 1'b0, 1'b0, 1'b0);
        run_cmd(5, 9, 1'b1, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule : coproc_block_move_sequencer_tb
bind move_sequencer move_seq_assertions chk (.CLK, .RESET, .COPRO_SOURCE_REG,
    .COPRO_DEST_REG, .REG_WRITE, .HOST_ADDRESS, .HOST_STROBE, .LOCAL_PORT_WORD_POINTER,
    .LOCAL_READ, .BUSY, .HIGH_WORD);
`default_nettype wire
